// ### common/reset_filter_pkg.sv
package reset_filter_pkg;
	// Clock and low-power oscillator timing.
	localparam int CLK_PERIOD_NS = 25;
	localparam int OSC_PERIOD_US = 1000;
	localparam int OSC_DIVIDE = OSC_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int OSC_DIV_BITS = 16;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] FILTER_CONTROL_INDEX = 10'h004;
	localparam logic [9:0] FILTER_WIDTH_INDEX = 10'h005;
	// Field layout of the control register.
	localparam int RUN_WAIT_SELECT_LSB = 0;
	localparam int STOP_SELECT_BIT = 2;
	localparam int CONTROL_BITS = 3;
	localparam int WIDTH_BITS = 5;
	localparam int COUNT_BITS = 6;
	// Values after power-on reset.
	localparam logic [2:0] CONTROL_RESET = 3'h0;
	localparam logic [4:0] WIDTH_RESET = 5'h00;
	// Run and wait selections.
	localparam logic [1:0] SELECT_OFF = 2'h0;
	localparam logic [1:0] SELECT_BUS = 2'h1;
	localparam logic [1:0] SELECT_OSC = 2'h2;
	// Fixed length of the low-power oscillator filter, in oscillator ticks.
	localparam logic [5:0] OSC_FILTER_COUNT = 6'h03;
	// The reset pin is active low, so its idle level is high.
	localparam logic PIN_IDLE = 1'h1;
	localparam logic [2:0] SYNC_RESET = 3'h7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### core/glitch_counter.sv
module glitch_counter
	import reset_filter_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst,
	// Control.
	input wire logic clear,
	input wire logic tick,
	input wire logic [reset_filter_pkg::COUNT_BITS-1:0] limit,
	// Level in and out.
	input wire logic din,
	output logic dout
);
	typedef struct packed
	{
		logic [COUNT_BITS-1:0] count;
		logic out;
	} state_type;

	state_type state;
	state_type next_state;

	always_comb
	begin
		next_state = state;
		if (clear)
		begin
			next_state.count = '0;
			next_state.out = din;
		end
		else if (din == state.out)
			next_state.count = '0;
		else if (tick)
		begin
			// A new level passes only after limit stable ticks in a row.
			if (state.count + 6'h01 >= limit)
			begin
				next_state.out = din;
				next_state.count = '0;
			end
			else
				next_state.count = state.count + 6'h01;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			state <= '{count: '0, out: PIN_IDLE};
		else
			state <= next_state;
	end

	assign dout = state.out;

	a_clear_empties: assert property (
		@(posedge mclk) disable iff (rst)
		clear |=> state.count == '0 && dout == $past(din))
		else $error("Cleared filter kept state.");
	// A change that follows a clear is a copy of the input, not a count.
	a_change_needs_count: assert property (
		@(posedge mclk) disable iff (rst)
		!$past(clear) && dout != $past(dout, 1) |->
		$past(state.count) + 6'h01 >= $past(limit))
		else $error("Filter output changed before count was reached.");
endmodule

// ### core/reset_pin_filter.sv
// Behaviour
// - The three control bits reset only on chip power-on reset.
// - The bus clock filter is cleared while disabled and while in stop.
// - The low-power oscillator filter is cleared while it is disabled.
// - In the stop family, select 0 is no filtering, 1 the oscillator filter.
// - In run and wait, 00 is off, 01 bus filter, 10 LOW_POWER_OSCILLATOR_CLOCK filter, 11 reserved.
// - Unused upper bits of both registers read as zero and ignore writes.
// - The bus filter count is the width field value plus one, 1 to 32.
// - The width field resets only on chip power-on reset.
module reset_pin_filter
	import reset_filter_pkg::*;
#(
	parameter int OSC_DIVIDE_CYCLES = reset_filter_pkg::OSC_DIVIDE
)
(
	// Clock and power-on reset.
	input wire logic mclk,
	input wire logic rst,
	// Reset of any other kind; filter state and write_pending only.
	input wire logic warm_reset,
	// Power mode.
	input wire logic stop_mode,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Reset pin and filtered result, both active low.
	input wire logic reset_pin_n,
	output logic filtered_reset_n
);
	import reset_filter_pkg::*;

	typedef struct packed
	{
		logic [CONTROL_BITS-1:0] control;
		logic [WIDTH_BITS-1:0] width;
		logic write_pending;
		logic [9:0] write_index;
		logic [31:0] rdata;
		logic [2:0] sync;
		logic pin_level;
		logic [OSC_DIV_BITS-1:0] osc_div;
		logic osc_tick;
	} state_type;

	state_type state;
	state_type next_state;
	logic [1:0] run_wait_filter_select;
	logic stop_mode_filter_select;
	logic bus_enable;
	logic osc_enable;
	logic bus_out;
	logic osc_out;
	logic [COUNT_BITS-1:0] bus_limit;
	logic address_phase;

	assign run_wait_filter_select =
		state.control[RUN_WAIT_SELECT_LSB +: 2];
	assign stop_mode_filter_select = state.control[STOP_SELECT_BIT];
	assign address_phase = hsel && hready && htrans == HTRANS_NONSEQ;

	// The reserved run-wait code enables neither filter.
	always_comb
	begin
		if (stop_mode)
		begin
			bus_enable = 1'b0;
			osc_enable = stop_mode_filter_select;
		end
		else
		begin
			bus_enable = run_wait_filter_select == SELECT_BUS;
			osc_enable = run_wait_filter_select == SELECT_OSC;
		end
	end

	assign bus_limit = {1'b0, state.width} + 6'h01;

	always_comb
	begin
		next_state = state;
		// Three stages; a change counts once the last two agree.
		next_state.sync = {state.sync[1:0], reset_pin_n};
		if (state.sync[1] == state.sync[2])
			next_state.pin_level = state.sync[2];
		// Oscillator ticks come from a divider so one clock serves both.
		next_state.osc_tick = 1'b0;
		if (state.osc_div >= OSC_DIV_BITS'(OSC_DIVIDE_CYCLES - 1))
		begin
			next_state.osc_div = '0;
			next_state.osc_tick = 1'b1;
		end
		else
			next_state.osc_div = state.osc_div + 16'h0001;
		// Data phase write; only the low bits are stored.
		if (state.write_pending)
		begin
			if (state.write_index == FILTER_CONTROL_INDEX)
				next_state.control = hwdata[CONTROL_BITS-1:0];
			if (state.write_index == FILTER_WIDTH_INDEX)
				next_state.width = hwdata[WIDTH_BITS-1:0];
		end
		next_state.write_pending = address_phase && hwrite;
		next_state.write_index = haddr[11:2];
		// Reads see a write from the previous data phase.
		if (address_phase && !hwrite)
		begin
			if (haddr[11:2] == FILTER_CONTROL_INDEX)
				next_state.rdata = {29'h0, next_state.control};
			else if (haddr[11:2] == FILTER_WIDTH_INDEX)
				next_state.rdata = {27'h0, next_state.width};
			else
				next_state.rdata = 32'h0;
		end
		// Other resets spare the configuration.
		if (warm_reset)
		begin
			next_state.write_pending = 1'b0;
			next_state.sync = SYNC_RESET;
			next_state.pin_level = PIN_IDLE;
			next_state.osc_div = '0;
			next_state.osc_tick = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= '0;
			state.control <= CONTROL_RESET;
			state.width <= WIDTH_RESET;
			state.sync <= SYNC_RESET;
			state.pin_level <= PIN_IDLE;
		end
		else
			state <= next_state;
	end

	glitch_counter bus_filter
	(
		.mclk(mclk),
		.rst(rst),
		.clear(!bus_enable || warm_reset),
		.tick(1'b1),
		.limit(bus_limit),
		.din(state.pin_level),
		.dout(bus_out)
	);

	glitch_counter osc_filter
	(
		.mclk(mclk),
		.rst(rst),
		.clear(!osc_enable || warm_reset),
		.tick(state.osc_tick),
		.limit(OSC_FILTER_COUNT),
		.din(state.pin_level),
		.dout(osc_out)
	);

	// Unfiltered path passes the qualified pin level straight through.
	always_comb
	begin
		if (bus_enable)
			filtered_reset_n = bus_out;
		else if (osc_enable)
			filtered_reset_n = osc_out;
		else
			filtered_reset_n = state.pin_level;
	end

	// Zero wait states keep the slave simple; the filter has no slow path.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = state.rdata;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_config_warm_hold: assert property (
		warm_reset && !state.write_pending |=> $stable(state.control))
		else $error("Control bits changed on a non power-on reset.");
	a_width_warm_hold: assert property (
		warm_reset && !state.write_pending |=> $stable(state.width))
		else $error("Width field changed on a non power-on reset.");
	a_stop_bus_off: assert property (
		stop_mode |-> !bus_enable ##1 bus_filter.state.count == '0)
		else $error("Bus filter active in stop mode.");
	a_osc_cleared: assert property (
		!osc_enable |=> osc_filter.state.count == '0)
		else $error("Oscillator filter kept state while disabled.");
	a_stop_select: assert property (
		stop_mode |-> osc_enable == state.control[STOP_SELECT_BIT])
		else $error("Stop select not honoured.");
	a_run_select: assert property (
		!stop_mode |-> bus_enable == (state.control[1:0] == 2'h1)
		&& osc_enable == (state.control[1:0] == 2'h2))
		else $error("Run and wait select not honoured.");
	a_reserved_zero: assert property (
		address_phase && !hwrite && haddr[11:2] == FILTER_CONTROL_INDEX
		|=> hrdata[31:3] == 29'h0)
		else $error("Reserved control bits read nonzero.");
	a_width_reserved: assert property (
		address_phase && !hwrite && haddr[11:2] == FILTER_WIDTH_INDEX
		|=> hrdata[31:5] == 27'h0)
		else $error("Reserved width bits read nonzero.");
	a_width_count: assert property (
		bus_enable && state.width == 5'h1f |-> bus_limit == 6'h20)
		else $error("Width code 31 does not give a count of 32.");
	a_bus_hold_time: assert property (
		bus_enable && $stable(bus_enable) && $changed(bus_out)
		&& !warm_reset |-> $past(state.pin_level) == bus_out)
		else $error("Bus filter passed a level the pin did not hold.");
	a_bypass_direct: assert property (
		!bus_enable && !osc_enable
		|-> filtered_reset_n == state.pin_level)
		else $error("Unfiltered path is not direct.");

	c_bus_pass: cover property (bus_enable ##1 $changed(bus_out));
	c_osc_pass: cover property (osc_enable ##1 $changed(osc_out));
	c_stop_entry: cover property (!stop_mode ##1 stop_mode);
	c_write_read: cover property (state.write_pending ##1 address_phase);
endmodule

// ### bench/reset_board.sv
module reset_board
(
	// Board push button.
	input wire logic press,
	// Pin, pulled up on the board, so it goes high when released.
	output logic reset_pin_n
);
	timeunit 1ns;
	timeprecision 100ps;
	assign reset_pin_n = !press;
endmodule

// ### bench/test_reset_pin_filter.sv
module test_reset_pin_filter;
	timeunit 1ns;
	timeprecision 100ps;
	import reset_filter_pkg::*;
	localparam logic [31:0] CTRL = {20'h0, FILTER_CONTROL_INDEX, 2'h0};
	localparam logic [31:0] WID = {20'h0, FILTER_WIDTH_INDEX, 2'h0};
	logic mclk, rst, warm_reset, stop_mode, hsel, hwrite, press;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp, reset_pin_n, filtered_reset_n, low;
	int num_errors, n_checks, cycles, d0, d;
	int d0_w[3] = '{0, 5, 31};
	// A short oscillator period keeps the run brief.
	localparam int OSC_DIV = 4;
	// Three pin stages, the qualified level, then the edge that sees it.
	localparam int SYNC_DELAY = 5;
	reset_board board_u (.press(press), .reset_pin_n(reset_pin_n));
	reset_pin_filter #(.OSC_DIVIDE_CYCLES(OSC_DIV)) dut_u (.mclk(mclk),
		.rst(rst),
		.warm_reset(warm_reset), .stop_mode(stop_mode), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .reset_pin_n(reset_pin_n),
		.filtered_reset_n(filtered_reset_n));
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic check_count(input int got, input int exp);
		n_checks++;
		if (got != exp)
		begin
			$display("wrong value at %0t: delay %0d want %0d", $time, got, exp);
			num_errors++;
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Cycles from pin press until the filtered reset falls, then release.
	task automatic measure(output int n);
		press <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (filtered_reset_n !== 1'b0 && n < 100);
		press <= 1'b0;
		repeat (100) @(posedge mclk);
	endtask
	// Short press; reports whether the filtered reset went low in the 60 cycles after release.
	task automatic glitch(input int len);
		press <= 1'b1;
		low = 1'b0;
		repeat (len) @(posedge mclk);
		press <= 1'b0;
		repeat (60)
		begin
			@(posedge mclk);
			if (filtered_reset_n !== 1'b1)
				low = 1'b1;
		end
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	initial
	begin
		{warm_reset, stop_mode, hsel, hwrite, press} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		rst = 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		bus(0, CTRL, 0);
		check_word(rd, 32'h0);
		bus(0, WID, 0);
		check_word(rd, 32'h0);
		bus(1, CTRL, 32'hffffffff);
		bus(1, WID, 32'hffffffff);
		bus(0, CTRL, 0);
		check_word(rd, 32'h7);
		bus(0, WID, 0);
		check_word(rd, 32'h1f);
		bus(0, 32'h18, 0);
		check_word(rd, 32'h0);
		warm_reset <= 1'b1;
		@(posedge mclk);
		warm_reset <= 1'b0;
		bus(0, CTRL, 0);
		check_word(rd, 32'h7);
		bus(0, WID, 0);
		check_word(rd, 32'h1f);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		bus(0, CTRL, 0);
		check_word(rd, 32'h0);
		bus(0, WID, 0);
		check_word(rd, 32'h0);
		$display("test registers done");
		measure(d0);
		check_count(d0, SYNC_DELAY);
		glitch(3);
		check_word({31'h0, low}, 32'h1);
		foreach (d0_w[i])
		begin
			bus(1, WID, d0_w[i]);
			bus(1, CTRL, 32'h1);
			measure(d);
			check_count(d - d0, d0_w[i] + 1);
		end
		glitch(20);
		check_word({31'h0, low}, 32'h0);
		bus(1, CTRL, 32'h0);
		glitch(3);
		check_word({31'h0, low}, 32'h1);
		$display("test bus filter done");
		bus(1, CTRL, 32'h3);
		measure(d);
		check_count(d, d0);
		bus(1, CTRL, 32'h2);
		glitch(2);
		check_word({31'h0, low}, 32'h0);
		// The tick phase is free running, so only whole ticks are counted.
		measure(d);
		check_count((d - d0 - 1) / OSC_DIV,
			OSC_FILTER_COUNT - 1);
		$display("test run selections done");
		bus(1, CTRL, 32'h1);
		stop_mode <= 1'b1;
		measure(d);
		check_count(d, d0);
		bus(1, CTRL, 32'h5);
		glitch(2);
		check_word({31'h0, low}, 32'h0);
		stop_mode <= 1'b0;
		bus(1, CTRL, 32'h5);
		measure(d);
		check_count(d - d0, 32);
		$display("test stop modes done");
		print_verdict();
	end
endmodule
